// File: cwr_ctrl.sv
// cwr_ctrl: configuration word store, program-memory access guard and reset sequencer
// assumes Avalon-MM master on i_clk; analog detectors and pins are asynchronous
`timescale 1ns/1ps
`default_nettype none

module cwr_ctrl
  import cwr_pkg::*;
#(
  parameter int POWERUP_TIMER_CYCLES = POWERUP_TIMER_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [15:0] i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output var  logic [31:0] o_avs_readdata,
  output var  logic        o_avs_waitrequest,
  input  wire logic        i_prog_mode,
  input  wire logic        i_por,
  input  wire logic        i_brownout_det,
  input  wire logic        i_overtemp,
  input  wire logic        i_master_clear_pin,
  input  wire logic        i_osc_startup_done,
  input  wire logic        i_sleep,
  input  wire logic        i_wdt_timeout,
  input  wire logic        i_wake_irq,
  input  wire logic [11:0] i_cpu_addr,
  output var  logic [13:0] o_cpu_rdata,
  input  wire logic        i_cpu_wr,
  input  wire logic [13:0] i_cpu_wdata,
  input  wire logic        i_pmc_wren,
  output var  logic        o_cpu_wr_blocked,
  output var  cwr_set_t    o_settings,
  output var  logic        o_core_rst,
  output var  logic        o_reg_reset,
  output var  logic        o_wake,
  output var  logic        o_bor_armed,
  output var  logic        o_expiry_flag_n,
  output var  logic        o_powerdown_flag_n
);

  localparam int          POWERUP_TIMER_LAST = POWERUP_TIMER_CYCLES - 1;
  localparam logic [7:0]  FILT_MAX  = 8'(MASTER_CLEAR_PIN_FILT_CYC);

  logic [SY_W-1:0] sync1;
  logic [SY_W-1:0] sync2;
  logic [13:0]     pmem [0:4095];
  logic [13:0]     id_mem [0:3];
  logic [13:0]     nv_cfg;
  logic [13:0]     idx;
  logic [31:0]     next_rdata;
  logic            wr_fire;
  logic            prog;
  logic            ext_pm_ok;
  logic [11:0]     prot_lim;
  logic            prot_hit;
  logic            cpu_wr_ok;
  logic [7:0]      filt_cnt;
  logic            pin_low;
  logic            master_clear_pin_hit;
  logic            por_s;
  logic            ot_s;
  logic            bor_hit;
  logic            wdt_hit;
  logic            rst_any;
  logic            wake_wdt;
  logic            wake_irq;
  logic            por_seen;
  logic [21:0]     powerup_timer_cnt;
  cwr_set_t        nv_set;
  cwr_state_t      state;
  cwr_state_t      next_state;
  cwr_cause_t      cause;

  // pin inputs: second stage alone feeds logic
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {i_osc_startup_done, i_master_clear_pin, i_overtemp, i_brownout_det, i_por, i_prog_mode};
      sync2 <= sync1;
    end
  end

  assign prog  = sync2[SY_PROG];
  assign por_s = sync2[SY_POR];
  assign ot_s  = sync2[SY_OT];
  assign idx   = i_avs_address[15:2];

  // ---------------- avalon slave: one wait cycle, then answer ----------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else if (!o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b1;
    end else if (i_avs_read || i_avs_write) begin
      o_avs_waitrequest <= 1'b0;
    end
  end

  assign wr_fire   = i_avs_write && !o_avs_waitrequest;
  assign ext_pm_ok = prog && o_settings.code_protect_n;

  always_comb begin
    next_rdata = '0;
    if (idx <= IDX_PMEM_TOP) begin
      if (ext_pm_ok) begin
        next_rdata[13:0] = pmem[idx[11:0]];
      end
    end else if (idx >= IDX_ID_FIRST && idx <= IDX_ID_LAST) begin
      if (prog) begin
        next_rdata[13:0] = id_mem[idx[1:0]];
      end
    end else if (idx == IDX_CFG) begin
      if (prog) begin
        next_rdata[13:0] = nv_cfg | CFG_UNUSED;
      end
    end else if (idx == IDX_STAT) begin
      next_rdata[STAT_TO_N]       = o_expiry_flag_n;
      next_rdata[STAT_PD_N]       = o_powerdown_flag_n;
      next_rdata[STAT_RUN]        = !o_core_rst;
      next_rdata[STAT_CAUSE +: 3] = cause;
      next_rdata[STAT_SET +: 8]   = o_settings;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_avs_readdata <= '0;
    end else if (o_avs_waitrequest && i_avs_read) begin
      o_avs_readdata <= next_rdata;
    end
  end

  // config word: i_rst models a fresh erased part; internal resets never touch it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      nv_cfg <= CFG_ERASED;
    end else if (wr_fire && prog && idx == IDX_CFG) begin
      nv_cfg <= i_avs_writedata[13:0] | CFG_UNUSED;
    end
  end

  assign nv_set = cwr_decode(nv_cfg);

  // ---------------- program memory and id words ----------------
  always_comb begin
    case (o_settings.self_write_protect_sel)
      2'b10:   prot_lim = PROT_LIM_1K;
      2'b01:   prot_lim = PROT_LIM_2K;
      default: prot_lim = PROT_LIM_ALL;
    endcase
    prot_hit = (o_settings.self_write_protect_sel != 2'b11) && (i_cpu_addr <= prot_lim);
  end

  assign cpu_wr_ok = i_cpu_wr && i_pmc_wren && !prot_hit && state == ST_RUN;

  // arrays carry no reset, so their content survives every reset
  always_ff @(posedge i_clk) begin
    if (wr_fire && idx <= IDX_PMEM_TOP && ext_pm_ok) begin
      pmem[idx[11:0]] <= i_avs_writedata[13:0];
    end else if (cpu_wr_ok) begin
      pmem[i_cpu_addr] <= i_cpu_wdata;
    end
    if (wr_fire && prog && idx >= IDX_ID_FIRST && idx <= IDX_ID_LAST) begin
      id_mem[idx[1:0]] <= i_avs_writedata[13:0];
    end
    o_cpu_rdata <= pmem[i_cpu_addr];
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cpu_wr_blocked <= 1'b0;
    end else begin
      o_cpu_wr_blocked <= i_cpu_wr && prot_hit;
    end
  end

  // ---------------- reset sources ----------------
  // a pin pulse must stay low for the whole filter span before it counts
  assign pin_low = !sync2[SY_PIN] && o_settings.ext_reset_pin_select;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      filt_cnt <= '0;
    end else if (!pin_low) begin
      filt_cnt <= '0;
    end else if (filt_cnt != FILT_MAX) begin
      filt_cnt <= filt_cnt + 8'h01;
    end
  end

  assign master_clear_pin_hit = pin_low && filt_cnt == FILT_MAX;
  assign bor_hit  = sync2[SY_BOR] && o_settings.brownout_enable && !i_sleep;
  assign wdt_hit  = i_wdt_timeout && o_settings.watchdog_enable && !i_sleep && state == ST_RUN;
  assign rst_any  = por_s || ot_s || master_clear_pin_hit || wdt_hit || bor_hit;
  assign wake_wdt = state == ST_RUN && i_sleep && i_wdt_timeout && o_settings.watchdog_enable;
  assign wake_irq = state == ST_RUN && i_sleep && i_wake_irq && !wake_wdt;

  // ---------------- start-up sequencer ----------------
  always_comb begin
    next_state = state;
    case (state)
      ST_LOAD: begin
        if (por_seen && nv_set.powerup_timer_on) begin
          next_state = ST_POWERUP_TIMER;
        end else begin
          next_state = ST_OST;
        end
      end
      ST_POWERUP_TIMER: begin
        if (powerup_timer_cnt == 22'(POWERUP_TIMER_LAST)) begin
          next_state = ST_OST;
        end
      end
      ST_OST: begin
        if (sync2[SY_OSC]) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: next_state = ST_RUN;
      default: next_state = ST_LOAD;
    endcase
    if (rst_any) begin
      next_state = ST_LOAD;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state       <= ST_LOAD;
      o_core_rst  <= 1'b1;
      o_reg_reset <= 1'b1;
    end else begin
      state       <= next_state;
      o_core_rst  <= next_state != ST_RUN;
      o_reg_reset <= next_state == ST_LOAD;
    end
  end

  // a brown-out during the timer sends us back through load, restarting it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      por_seen <= 1'b1;
    end else if (por_s) begin
      por_seen <= 1'b1;
    end else if (state == ST_OST) begin
      por_seen <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      powerup_timer_cnt <= '0;
    end else if (state != ST_POWERUP_TIMER) begin
      powerup_timer_cnt <= '0;
    end else begin
      powerup_timer_cnt <= powerup_timer_cnt + 22'h000001;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_settings <= SET_ERASED;
    end else if (state == ST_LOAD) begin
      o_settings <= nv_set;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wake      <= 1'b0;
      o_bor_armed <= 1'b0;
    end else begin
      o_wake      <= wake_wdt || wake_irq;
      o_bor_armed <= o_settings.brownout_enable && !i_sleep;
    end
  end

  // ---------------- reset cause flags ----------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_expiry_flag_n    <= 1'b1;
      o_powerdown_flag_n <= 1'b1;
      cause              <= CAUSE_POR;
    end else if (por_s) begin
      o_expiry_flag_n    <= 1'b1;
      o_powerdown_flag_n <= 1'b1;
      cause              <= CAUSE_POR;
    end else if (bor_hit) begin
      o_expiry_flag_n    <= 1'b1;
      o_powerdown_flag_n <= 1'b1;
      cause              <= CAUSE_BOR;
    end else if (wdt_hit) begin
      o_expiry_flag_n    <= 1'b0;
      cause              <= CAUSE_WDT;
    end else if (master_clear_pin_hit) begin
      if (i_sleep) begin
        o_expiry_flag_n    <= 1'b1;
        o_powerdown_flag_n <= 1'b0;
      end
      cause <= CAUSE_PIN;
    end else if (ot_s) begin
      cause <= CAUSE_OT;
    end else if (wake_wdt) begin
      o_expiry_flag_n    <= 1'b0;
      o_powerdown_flag_n <= 1'b0;
      cause              <= CAUSE_WAKE_WDT;
    end else if (wake_irq) begin
      o_expiry_flag_n    <= 1'b1;
      o_powerdown_flag_n <= 1'b0;
      cause              <= CAUSE_WAKE_IRQ;
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_rd_done;
    !o_avs_waitrequest && i_avs_read;
  endsequence

  sequence s_wdt_wake;
    wake_wdt && !rst_any;
  endsequence

  a_cfg_unused_ones: assert property (s_rd_done and (idx == IDX_CFG && $past(prog))
    |-> (o_avs_readdata[13:0] & CFG_UNUSED) == CFG_UNUSED) else $error("unused config bits not one");

  a_cp_read_zero: assert property (s_rd_done and (idx <= IDX_PMEM_TOP
    && !$past(o_settings.code_protect_n)) |-> o_avs_readdata == 32'h0) else $error("protected read not zero");

  a_sw_protect_low: assert property (i_cpu_wr && i_cpu_addr <= PROT_LIM_1K
    && o_settings.self_write_protect_sel != 2'b11 |=> o_cpu_wr_blocked) else $error("protected write not blocked");

  a_powerup_timer_hold: assert property (state == ST_POWERUP_TIMER && powerup_timer_cnt != 22'(POWERUP_TIMER_LAST) && !rst_any
    |=> state == ST_POWERUP_TIMER && o_core_rst) else $error("power-up timer left early");

  a_powerup_timer_por_only: assert property (state == ST_LOAD && !rst_any && !por_seen
    |=> state == ST_OST) else $error("power-up timer without power-on");

  a_run_gate: assert property ($fell(o_core_rst)
    |-> $past(sync2[SY_OSC]) && $past(state) == ST_OST) else $error("run before start-up done");

  a_wdt_wake_flags: assert property (s_wdt_wake
    |=> !o_expiry_flag_n && !o_powerdown_flag_n && !o_reg_reset && !o_core_rst) else $error("bad watchdog wake");

  a_por_flags_set: assert property (por_s
    |=> o_expiry_flag_n && o_powerdown_flag_n && o_core_rst && o_reg_reset) else $error("bad power-on flags");

  a_cfg_frozen: assert property (state == ST_RUN && $past(state) == ST_RUN
    |-> $stable(o_settings)) else $error("settings changed while running");

  a_master_clear_pin_glitch: assert property (!pin_low |=> !master_clear_pin_hit) else $error("pin glitch caused reset");

  a_bor_sleep_off: assert property (state == ST_RUN && i_sleep && !por_s && !ot_s && !master_clear_pin_hit
    |=> !o_core_rst) else $error("brown-out acted in sleep");

endmodule : cwr_ctrl

`default_nettype wire

// File: cwr_pkg.sv
// cwr_pkg: constants, types and decode for the configuration word and reset control block
// assumes a single 40 MHz clock; register indices are word indices, byte address is index * 4
package cwr_pkg;

  localparam int CLK_HZ        = 40_000_000;
  localparam int POWERUP_TIMER_MS       = 64;
  localparam int POWERUP_TIMER_CYC      = (CLK_HZ / 1000) * POWERUP_TIMER_MS;
  localparam int MASTER_CLEAR_PIN_FILT_NS  = 2000;
  localparam int MASTER_CLEAR_PIN_FILT_CYC = (MASTER_CLEAR_PIN_FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // register word indices
  localparam logic [13:0] IDX_PMEM_TOP = 14'h0fff;
  localparam logic [13:0] IDX_ID_FIRST = 14'h2000;
  localparam logic [13:0] IDX_ID_LAST  = 14'h2003;
  localparam logic [13:0] IDX_CFG      = 14'h2007;
  localparam logic [13:0] IDX_STAT     = 14'h2010;

  // configuration word fields
  localparam int          BIT_DBG_N    = 13;
  localparam int          BIT_WRT_LO   = 10;
  localparam int          BIT_BROWNOUT_ENABLE    = 8;
  localparam int          BIT_CP_N     = 6;
  localparam int          BIT_EXT_RESET_PIN_SELECT    = 5;
  localparam int          BIT_POWERUP_TIMER_ENABLE_N_N  = 4;
  localparam int          BIT_WATCHDOG_ENABLE     = 3;
  localparam logic [13:0] CFG_UNUSED   = 14'h1287;
  localparam logic [13:0] CFG_ERASED   = 14'h3fff;

  // self-write protection upper limits
  localparam logic [11:0] PROT_LIM_1K  = 12'h3ff;
  localparam logic [11:0] PROT_LIM_2K  = 12'h7ff;
  localparam logic [11:0] PROT_LIM_ALL = 12'hfff;

  // status register fields
  localparam int STAT_TO_N    = 0;
  localparam int STAT_PD_N    = 1;
  localparam int STAT_RUN     = 2;
  localparam int STAT_CAUSE   = 4;
  localparam int STAT_SET     = 8;

  // pin synchroniser lanes
  localparam int SY_PROG = 0;
  localparam int SY_POR  = 1;
  localparam int SY_BOR  = 2;
  localparam int SY_OT   = 3;
  localparam int SY_PIN  = 4;
  localparam int SY_OSC  = 5;
  localparam int SY_W    = 6;

  typedef struct packed {
    logic       in_circuit_debug;
    logic [1:0] self_write_protect_sel;
    logic       brownout_enable;
    logic       code_protect_n;
    logic       ext_reset_pin_select;
    logic       powerup_timer_on;
    logic       watchdog_enable;
  } cwr_set_t;

  localparam cwr_set_t SET_ERASED = 8'h7d;

  typedef enum logic [1:0] {ST_LOAD, ST_POWERUP_TIMER, ST_OST, ST_RUN} cwr_state_t;

  typedef enum logic [2:0] {
    CAUSE_POR, CAUSE_BOR, CAUSE_OT, CAUSE_PIN, CAUSE_WDT, CAUSE_WAKE_WDT, CAUSE_WAKE_IRQ
  } cwr_cause_t;

  function automatic cwr_set_t cwr_decode(input logic [13:0] w);
    cwr_set_t s;
    s.in_circuit_debug       = ~w[BIT_DBG_N];
    s.self_write_protect_sel = w[BIT_WRT_LO +: 2];
    s.brownout_enable        = w[BIT_BROWNOUT_ENABLE];
    s.code_protect_n         = w[BIT_CP_N];
    s.ext_reset_pin_select   = w[BIT_EXT_RESET_PIN_SELECT];
    s.powerup_timer_on       = ~w[BIT_POWERUP_TIMER_ENABLE_N_N];
    s.watchdog_enable        = w[BIT_WATCHDOG_ENABLE];
    return s;
  endfunction : cwr_decode

endpackage : cwr_pkg

// File: cwr_prog_model.sv
// cwr_prog_model: programmer in program/verify mode, Avalon master towards the block
// assumes the bench calls one task at a time and drives nothing on this bus itself
`timescale 1ns/1ps
`default_nettype none
module cwr_prog_model (
  input  wire logic        i_clk,
  input  wire logic        i_waitrequest,
  output var  logic [15:0] o_address,
  output var  logic        o_read,
  output var  logic        o_write,
  output var  logic [31:0] o_writedata,
  output var  logic        o_prog_mode,
  output var  logic        o_timeout
);
  initial begin
    o_address = 16'h0000;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h0000_0000;
    o_prog_mode = 1'b0;
    o_timeout = 1'b0;
  end
  // request held until waitrequest is seen low at a rising edge
  task automatic acc(input logic wr, input logic [15:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge i_clk);
    o_address <= addr;
    o_read <= ~wr;
    o_write <= wr;
    o_writedata <= data;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) o_timeout <= 1'b1;
    o_read <= 1'b0;
    o_write <= 1'b0;
    // released data must not look valid
    o_writedata <= ~data;
  endtask : acc
  // debug bit kept at one so the part never runs with debug left on
  task automatic cfg(input logic [13:0] w);
    acc(1'b1, 16'h801c, {18'h0, 1'b1, w[12:0]});
  endtask : cfg
endmodule : cwr_prog_model
`default_nettype wire

// File: tb.sv
// tb: self-checking bench for cwr_ctrl, reads checked from a queue of notes
// assumes 40 MHz clock, oscillator start-up already done, short power-up timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
  import cwr_pkg::*;
  localparam int PW = 20;
  logic i_clk = 0, i_rst = 1, i_por = 0, i_bod = 0, i_ot = 0, i_pin = 1, i_sleep = 0;
  logic i_wdt = 0, i_irq = 0, i_cpu_wr = 0, i_pmc_wren = 0;
  logic [11:0] i_cpu_addr = 12'h000;
  logic [13:0] i_cpu_wdata = 14'h0000, cpu_rdata, w;
  logic [15:0] avs_addr, seed = 16'hd1e0;
  logic [31:0] avs_wd, avs_rdata, ex;
  logic avs_rd, avs_wr, avs_wait, prog_mode, prog_to, blocked, core_rst, reg_rst, wake, bor_armed, to_n, pd_n;
  logic saw_wake, saw_reg, pr;
  logic [7:0] es;
  cwr_set_t settings;
  logic [31:0] expq[$];
  logic [11:0] ca[4] = '{12'h3ff, 12'h400, 12'h7ff, 12'h800};
  int fails = 0, check_count = 0, n;
  always #12.5 i_clk = ~i_clk;
  cwr_prog_model prog (.i_clk(i_clk), .i_waitrequest(avs_wait), .o_address(avs_addr), .o_read(avs_rd),
    .o_write(avs_wr), .o_writedata(avs_wd), .o_prog_mode(prog_mode), .o_timeout(prog_to));
  cwr_ctrl #(.POWERUP_TIMER_CYCLES(PW)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(avs_addr),
    .i_avs_read(avs_rd), .i_avs_write(avs_wr), .i_avs_writedata(avs_wd), .o_avs_readdata(avs_rdata),
    .o_avs_waitrequest(avs_wait), .i_prog_mode(prog_mode), .i_por(i_por), .i_brownout_det(i_bod),
    .i_overtemp(i_ot), .i_master_clear_pin(i_pin), .i_osc_startup_done(1'b1), .i_sleep(i_sleep),
    .i_wdt_timeout(i_wdt), .i_wake_irq(i_irq), .i_cpu_addr(i_cpu_addr), .o_cpu_rdata(cpu_rdata),
    .i_cpu_wr(i_cpu_wr), .i_cpu_wdata(i_cpu_wdata), .i_pmc_wren(i_pmc_wren), .o_cpu_wr_blocked(blocked),
    .o_settings(settings), .o_core_rst(core_rst), .o_reg_reset(reg_rst), .o_wake(wake),
    .o_bor_armed(bor_armed), .o_expiry_flag_n(to_n), .o_powerdown_flag_n(pd_n));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", fails, check_count);
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
  endtask : cyc
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    expq.push_back(e);
    prog.acc(1'b0, a, 32'h0);
  endtask : rd
  task automatic wait_core(input logic lvl, output int k);
    k = 0;
    while (core_rst !== lvl && k < 400) begin
      @(posedge i_clk);
      k++;
    end
    if (k >= 400) begin
      fails++;
      complete_run();
    end
  endtask : wait_core
  task automatic power_on(output int k);
    @(posedge i_clk);
    i_por <= 1'b1;
    cyc(4);
    i_por <= 1'b0;
    wait_core(1'b0, k);
  endtask : power_on
  // reads are judged where the answer appears, against the oldest note
  always @(posedge i_clk) begin
    if (avs_rd && avs_wait === 1'b0) begin
      if (expq.size() == 0) begin
        fails++;
        $display("wrong value at %0t: read without a note", $time);
      end else begin
        ex = expq.pop_front();
        `CHK(avs_rdata, ex)
      end
    end
    if (wake === 1'b1) saw_wake <= 1'b1;
    if (reg_rst === 1'b1) saw_reg <= 1'b1;
  end
  always @(posedge prog_to) begin
    fails++;
    complete_run();
  end
  initial begin
    cyc(6);
    i_rst <= 1'b0;
    cyc(3);
    `CHK(settings, 8'h7d)
    `CHK({to_n, pd_n}, 2'b11)
    prog.o_prog_mode <= 1'b1;
    cyc(4);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr_next(seed);
      prog.acc(1'b1, 16'(16'h8000 + 4 * i), {16'h0, seed});
      rd(16'(16'h8000 + 4 * i), {18'h0, seed[13:0]});
    end
    rd(16'h8020, 32'h0);
    prog.o_prog_mode <= 1'b0;
    cyc(4);
    rd(16'h8000, 32'h0);
    rd(16'h801c, 32'h0);
    prog.o_prog_mode <= 1'b1;
    cyc(4);
    for (int s = 0; s < 4; s++) begin
      seed = lfsr_next(seed);
      w = {1'b1, seed[12], 2'(s), seed[9:0]};
      prog.cfg(w);
      rd(16'h801c, {18'h0, w | 14'h1287});
      power_on(n);
      es = {~w[13], w[11:10], w[8], w[6], w[5], ~w[4], w[3]};
      `CHK(settings, es)
      `CHK(n >= PW, ~w[4])
      foreach (ca[j]) begin
        seed = lfsr_next(seed);
        @(posedge i_clk);
        i_cpu_addr <= ca[j];
        i_cpu_wdata <= seed[13:0];
        i_cpu_wr <= 1'b1;
        i_pmc_wren <= 1'b1;
        @(posedge i_clk);
        i_cpu_wr <= 1'b0;
        @(posedge i_clk);
        pr = (s == 0) || (s == 1 && ca[j] <= 12'h7ff) || (s == 2 && ca[j] <= 12'h3ff);
        `CHK(blocked, pr)
        @(posedge i_clk);
        if (!pr) `CHK(cpu_rdata, seed[13:0])
      end
      if (s == 3) begin
        @(posedge i_clk);
        i_cpu_wdata <= ~seed[13:0];
        i_cpu_wr <= 1'b1;
        i_pmc_wren <= 1'b0;
        @(posedge i_clk);
        i_cpu_wr <= 1'b0;
        cyc(2);
        `CHK(cpu_rdata, seed[13:0])
      end
      prog.acc(1'b1, 16'h1000, {16'h0, seed});
      rd(16'h1000, w[6] ? {18'h0, seed[13:0]} : 32'h0);
      prog.cfg(~w);
      cyc(3);
      `CHK(settings, es)
    end
    prog.cfg(14'h3fff);
    power_on(n);
    @(posedge i_clk);
    i_pin <= 1'b0;
    cyc(20);
    i_pin <= 1'b1;
    cyc(4);
    `CHK(core_rst, 1'b0)
    i_pin <= 1'b0;
    wait_core(1'b1, n);
    i_pin <= 1'b1;
    wait_core(1'b0, n);
    `CHK(n > 0, 1'b1)
    i_sleep <= 1'b1;
    cyc(3);
    `CHK(bor_armed, 1'b0)
    i_bod <= 1'b1;
    cyc(5);
    i_bod <= 1'b0;
    `CHK(core_rst, 1'b0)
    saw_wake <= 1'b0;
    saw_reg <= 1'b0;
    i_wdt <= 1'b1;
    @(posedge i_clk);
    i_wdt <= 1'b0;
    cyc(4);
    `CHK({to_n, pd_n, core_rst, saw_wake, saw_reg}, 5'b00010)
    i_irq <= 1'b1;
    @(posedge i_clk);
    i_irq <= 1'b0;
    cyc(4);
    `CHK({to_n, pd_n}, 2'b10)
    i_sleep <= 1'b0;
    cyc(2);
    `CHK(bor_armed, 1'b1)
    i_wdt <= 1'b1;
    @(posedge i_clk);
    i_wdt <= 1'b0;
    wait_core(1'b1, n);
    wait_core(1'b0, n);
    `CHK({to_n, saw_reg}, 2'b01)
    i_ot <= 1'b1;
    cyc(4);
    i_ot <= 1'b0;
    wait_core(1'b1, n);
    wait_core(1'b0, n);
    `CHK(to_n, 1'b0)
    i_bod <= 1'b1;
    cyc(4);
    i_bod <= 1'b0;
    wait_core(1'b1, n);
    wait_core(1'b0, n);
    `CHK({to_n, pd_n}, 2'b11)
    rd(16'h8040, 32'h0000_7d17);
    cyc(2);
    `CHK(expq.size(), 0)
    complete_run();
  end
endmodule : tb
`default_nettype wire
